// ---- rtl/smcf_pkg.sv ----
package smcf_pkg;
  // Configuration offsets, in bytes within the function's header space.
  localparam logic [7:0] SMCF_OFF_CMD = 8'h04;
  localparam logic [7:0] SMCF_OFF_STS = 8'h06;
  localparam logic [7:0] SMCF_OFF_REV = 8'h08;
  localparam logic [7:0] SMCF_OFF_SCC = 8'h0A;
  localparam logic [7:0] SMCF_OFF_BCC = 8'h0B;
  localparam logic [7:0] SMCF_OFF_BASE = 8'h20;
  localparam logic [7:0] SMCF_OFF_SUBSYSTEM_VENDOR = 8'h2C;
  localparam logic [7:0] SMCF_OFF_SID = 8'h2E;
  localparam logic [7:0] SMCF_OFF_ILN = 8'h3C;
  // Status and command field positions.
  localparam int SMCF_STS_TAS = 11;
  localparam int SMCF_STS_INTP = 3;
  localparam int SMCF_CMD_IDIS = 10;
  // Fixed and reset values.
  localparam logic [15:0] SMCF_STS_RST = 16'h0280;
  localparam logic [15:0] SMCF_STS_FIXED = 16'h0280;
  localparam logic [7:0] SMCF_SCC_VAL = 8'h05;
  localparam logic [7:0] SMCF_BCC_VAL = 8'h0C;
  localparam logic [31:0] SMCF_BASE_RST = 32'h00000001;
  localparam logic [31:0] SMCF_BASE_WMASK = 32'h0000FFE0;
  localparam logic [31:0] SMCF_BASE_FIXED = 32'h00000001;
  localparam logic [7:0] SMCF_ILN_RST = 8'h00;
  localparam logic [15:0] SMCF_CMD_WMASK = 16'h0401;
  localparam logic [15:0] SMCF_CMD_RST = 16'h0000;
  localparam logic [15:0] SMCF_SUBSYS_RST = 16'h0000;
endpackage

// ---- rtl/smcf_sub_if.sv ----
`timescale 1ns/1ps
// Subsystem identity mirror: capture strobes from the IDE function and held copies.
interface smcf_sub_if;
  logic vend_we;
  logic ident_we;
  logic [15:0] wdata;
  logic [15:0] vend;
  logic [15:0] ident;
  modport owner (input vend_we, input ident_we, input wdata, output vend, output ident);
  modport user (output vend_we, output ident_we, output wdata, input vend, input ident);
endinterface

// ---- rtl/smcf_sub_mirror.sv ----
`timescale 1ns/1ps
module smcf_sub_mirror
  import smcf_pkg::*;
(
  input wire ref_clk,
  input wire arst_n,
  smcf_sub_if.owner sub
);
  logic [15:0] vend_q, vend_d, ident_q, ident_d;

  // Track the last value firmware wrote into the IDE function's copies.
  always_comb begin
    vend_d = sub.vend_we ? sub.wdata : vend_q;
    ident_d = sub.ident_we ? sub.wdata : ident_q;
  end

  // Hold the mirrored identity words.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      vend_q <= SMCF_SUBSYS_RST;
      ident_q <= SMCF_SUBSYS_RST;
    end else begin
      vend_q <= vend_d;
      ident_q <= ident_d;
    end
  end

  assign sub.vend = vend_q;
  assign sub.ident = ident_q;

  a_vend_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sub.vend_we |=> sub.vend == $past(sub.wdata)) else $error("Vendor mirror missed a write.");
  a_ident_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sub.ident_we |=> sub.ident == $past(sub.wdata)) else $error("Ident mirror missed a write.");
endmodule

// ---- rtl/smcf_cfg_header.sv ----
`timescale 1ns/1ps
module smcf_cfg_header
  import smcf_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h00
)
(
  input wire ref_clk,
  input wire arst_n,
  input wire cfg_rd,
  input wire cfg_wr,
  input wire [7:0] cfg_addr,
  input wire [3:0] cfg_be,
  input wire [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire tgt_abort,
  input wire irq_pending,
  input wire ide_vend_we,
  input wire ide_ident_we,
  input wire [15:0] ide_wdata,
  output logic shared_irq_request_out,
  output logic io_space_en,
  output logic [15:0] io_window_base
);
  smcf_sub_if sub ();

  logic tas_q, tas_d;
  logic [31:0] base_q, base_d;
  logic [7:0] iln_q, iln_d;
  logic [15:0] cmd_q, cmd_d;
  logic [31:0] rdata_d;
  logic [31:0] wmask;
  logic [5:0] dw;
  logic [15:0] sts_val;

  assign sub.vend_we = ide_vend_we;
  assign sub.ident_we = ide_ident_we;
  assign sub.wdata = ide_wdata;

  smcf_sub_mirror u_mirror (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sub(sub)
  );

  // Byte enables widened into a bit mask; dword index of the access.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{cfg_be[i]}};
    end
    dw = cfg_addr[7:2];
  end

  // Assembled status word: fixed bits, sticky abort, live pending flag.
  always_comb begin
    sts_val = SMCF_STS_FIXED;
    sts_val[SMCF_STS_TAS] = tas_q;
    sts_val[SMCF_STS_INTP] = irq_pending;
  end

  // Next values of the writable state.
  always_comb begin
    logic [31:0] hi;
    hi = cfg_wdata & wmask;
    tas_d = tas_q;
    base_d = base_q;
    iln_d = iln_q;
    cmd_d = cmd_q;
    if (cfg_wr && dw == SMCF_OFF_CMD[7:2]) begin
      // Command in low half, status in high half of the dword.
      cmd_d = (cmd_q & ~(SMCF_CMD_WMASK & hi[15:0] | SMCF_CMD_WMASK & wmask[15:0]))
            | (hi[15:0] & SMCF_CMD_WMASK);
      if (hi[16 + SMCF_STS_TAS]) begin
        tas_d = 1'b0;
      end
    end
    if (tgt_abort) begin
      tas_d = 1'b1;
    end
    if (cfg_wr && dw == SMCF_OFF_BASE[7:2]) begin
      base_d = (base_q & ~(SMCF_BASE_WMASK & wmask)) | (hi & SMCF_BASE_WMASK) | SMCF_BASE_FIXED;
    end
    if (cfg_wr && dw == SMCF_OFF_ILN[7:2] && cfg_be[0]) begin
      iln_d = cfg_wdata[7:0];
    end
  end

  // Read mux; unmapped dwords return zero.
  always_comb begin
    rdata_d = cfg_rdata;
    if (cfg_rd) begin
      case (dw)
        SMCF_OFF_CMD[7:2]: rdata_d = {sts_val, cmd_q};
        SMCF_OFF_REV[7:2]: rdata_d = {SMCF_BCC_VAL, SMCF_SCC_VAL, 8'h00, REVISION};
        SMCF_OFF_BASE[7:2]: rdata_d = base_q;
        SMCF_OFF_SUBSYSTEM_VENDOR[7:2]: rdata_d = {sub.ident, sub.vend};
        SMCF_OFF_ILN[7:2]: rdata_d = {24'h000000, iln_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // Register the state and the read data.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tas_q <= SMCF_STS_RST[SMCF_STS_TAS];
      base_q <= SMCF_BASE_RST;
      iln_q <= SMCF_ILN_RST;
      cmd_q <= SMCF_CMD_RST;
      cfg_rdata <= 32'h00000000;
    end else begin
      tas_q <= tas_d;
      base_q <= base_d;
      iln_q <= iln_d;
      cmd_q <= cmd_d;
      cfg_rdata <= rdata_d;
    end
  end

  // Shared interrupt output, gated by the disable bit in command.
  assign shared_irq_request_out = irq_pending & ~cmd_q[SMCF_CMD_IDIS];
  assign io_space_en = cmd_q[0];
  assign io_window_base = base_q[15:0];

  a_abort_sets: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tgt_abort |=> tas_q) else $error("Abort flag not set.");
  a_zero_keeps: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tas_q && !(cfg_wr && dw == SMCF_OFF_CMD[7:2] && cfg_wdata[16 + SMCF_STS_TAS] && cfg_be[3]) |=> tas_q)
    else $error("Abort flag lost without a one write.");
  a_fixed_sts: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (sts_val & 16'hF7F7) == SMCF_STS_FIXED) else $error("Fixed status bits wrong.");
  a_fb2b_one: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sts_val[7]) else $error("Back-to-back bit not one.");
  a_zero_bits: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (sts_val & 16'hF177) == 16'h0000) else $error("Hardwired zero bits set.");
  a_pend_show: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sts_val[SMCF_STS_INTP] == irq_pending) else $error("Pending bit not live.");
  a_base_io: assert property (@(posedge ref_clk) disable iff (!arst_n)
    base_q[0] && base_q[31:16] == 16'h0000 && base_q[4:1] == 4'h0) else $error("Base fixed bits wrong.");
  a_irq_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cmd_q[SMCF_CMD_IDIS] |-> !shared_irq_request_out) else $error("Interrupt not blocked.");
  a_read_sts: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cfg_rd && dw == SMCF_OFF_CMD[7:2] |=> cfg_rdata[31:16] == $past(sts_val)) else $error("Status read wrong.");

  // A one written to the abort flag position in the upper status byte.
  sequence s_abort_clear_write;
    cfg_wr && dw == SMCF_OFF_CMD[7:2] && cfg_be[3] && cfg_wdata[16 + SMCF_STS_TAS];
  endsequence

  // A clear that does not collide with a new abort must drop the flag.
  sequence s_clear_alone;
    s_abort_clear_write ##0 !tgt_abort;
  endsequence

  // A clear colliding with an abort leaves the flag set, because the set wins.
  sequence s_clear_collides;
    s_abort_clear_write ##0 tgt_abort;
  endsequence

  a_one_clears: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_clear_alone |=> !tas_q) else $error("Abort flag not cleared by a one.");
  a_set_wins: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_clear_collides |=> tas_q) else $error("Abort lost against a clear.");

  // The base window only moves when software writes its dword.
  a_base_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !(cfg_wr && dw == SMCF_OFF_BASE[7:2]) |=> base_q == $past(base_q)) else $error("Base moved without a write.");

  // The routing byte only changes on a write to its own byte lane.
  a_line_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !(cfg_wr && dw == SMCF_OFF_ILN[7:2] && cfg_be[0]) |=> iln_q == $past(iln_q)) else $error("Line byte moved.");

  // Command bits outside the kept enables stay zero.
  a_cmd_fixed: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (cmd_q & ~SMCF_CMD_WMASK) == 16'h0000) else $error("Reserved command bits set.");
endmodule

// ---- dv/smcf_host_bfm.sv ----
`timescale 1ns/1ps
// Host bridge model: issues single configuration cycles, one request at a time.
module smcf_host_bfm (
  input wire ref_clk,
  input wire [31:0] cfg_rdata,
  output logic cfg_rd,
  output logic cfg_wr,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata
);
  // Quiet bus at time zero.
  initial begin
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h00000000;
  end

  // One write cycle; released data shows the inverse so stale values never look valid.
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    cfg_wdata <= ~d;
    @(posedge ref_clk);
  endtask

  // One read cycle; data is taken the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    cfg_addr <= a;
    cfg_be <= 4'hF;
    cfg_rd <= 1'b1;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    @(posedge ref_clk);
    q = cfg_rdata;
  endtask
endmodule

// ---- dv/smcf_cfg_header_tb.sv ----
`timescale 1ns/1ps
module smcf_cfg_header_tb;
  import smcf_pkg::*;
  localparam logic [7:0] REV = 8'h3A;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic tgt_abort = 1'b0;
  logic irq_pending = 1'b0;
  logic ide_vend_we = 1'b0;
  logic ide_ident_we = 1'b0;
  logic [15:0] ide_wdata = 16'h0000;
  logic cfg_rd, cfg_wr, irq_out, io_en;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [15:0] io_base;
  logic [31:0] cfg_wdata, cfg_rdata, d;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  smcf_host_bfm u_host (.ref_clk(ref_clk), .cfg_rdata(cfg_rdata), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
  smcf_cfg_header #(.REVISION(REV)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .cfg_rd(cfg_rd),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .tgt_abort(tgt_abort), .irq_pending(irq_pending), .ide_vend_we(ide_vend_we),
    .ide_ident_we(ide_ident_we), .ide_wdata(ide_wdata), .shared_irq_request_out(irq_out),
    .io_space_en(io_en), .io_window_base(io_base));

  // Expected dword at 04h: fixed status pattern, abort flag, pending flag, command.
  function automatic logic [31:0] hdr(input logic target_abort_signalled, input logic ip, input logic [15:0] cmd);
    return {4'h0, target_abort_signalled, 4'h5, 3'h0, ip, 3'h0, cmd};
  endfunction

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_host.rd(a, q);
    chk(e, q);
  endtask

  // Firmware write into the IDE function's subsystem copy.
  task automatic mir(input logic sel, input logic [15:0] w);
    ide_wdata <= w;
    ide_vend_we <= sel;
    ide_ident_we <= ~sel;
    @(posedge ref_clk);
    ide_vend_we <= 1'b0;
    ide_ident_we <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      conclude();
    end
  end

  // Main sequence: reset values, fixed bits, abort flag, then random traffic.
  initial begin
    void'($urandom(11));
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rc(SMCF_OFF_CMD, hdr(1'b0, 1'b0, 16'h0000));
    rc(SMCF_OFF_REV, {8'h0C, 8'h05, 8'h00, REV});
    rc(SMCF_OFF_BASE, 32'h00000001);
    rc(SMCF_OFF_SUBSYSTEM_VENDOR, 32'h00000000);
    rc(SMCF_OFF_ILN, 32'h00000000);
    $display("test reset ended");
    irq_pending <= 1'b1;
    u_host.wr(SMCF_OFF_CMD, 4'hF, 32'hFFFFFFFF);
    rc(SMCF_OFF_CMD, hdr(1'b0, 1'b1, 16'h0401));
    chk({30'h0, irq_out, io_en}, 32'h00000001);
    $display("test fixed bits ended");
    tgt_abort <= 1'b1;
    u_host.wr(SMCF_OFF_CMD, 4'hC, 32'h08000000);
    tgt_abort <= 1'b0;
    rc(SMCF_OFF_CMD, hdr(1'b1, 1'b1, 16'h0401));
    u_host.wr(SMCF_OFF_CMD, 4'hF, 32'h00000000);
    rc(SMCF_OFF_CMD, hdr(1'b1, 1'b1, 16'h0000));
    u_host.wr(SMCF_OFF_STS, 4'hC, 32'h08000000);
    rc(SMCF_OFF_CMD, hdr(1'b0, 1'b1, 16'h0000));
    $display("test abort flag ended");
    for (int n = 0; n < 8; n++) begin
      d = (n == 0) ? 32'hFFFFFFFF : $urandom;
      irq_pending <= d[31];
      u_host.wr(SMCF_OFF_BASE, 4'hF, d);
      u_host.wr(SMCF_OFF_ILN, 4'hF, ~d);
      u_host.wr(SMCF_OFF_REV, 4'hF, d);
      u_host.wr(SMCF_OFF_CMD, 4'h3, d);
      mir(1'b1, d[15:0]);
      mir(1'b0, d[31:16]);
      rc(SMCF_OFF_BASE, {16'h0000, d[15:5], 5'h01});
      chk({16'h0000, io_base}, {16'h0000, d[15:5], 5'h01});
      rc(SMCF_OFF_ILN, {24'h000000, ~d[7:0]});
      rc(SMCF_OFF_REV, {8'h0C, 8'h05, 8'h00, REV});
      rc(SMCF_OFF_SUBSYSTEM_VENDOR, d);
      rc(SMCF_OFF_CMD, hdr(1'b0, d[31], d[15:0] & 16'h0401));
      rc(8'h10, 32'h00000000);
      chk({31'h0, irq_out}, {31'h0, d[31] & ~d[10]});
    end
    $display("test random ended");
    conclude();
  end
endmodule
